// ### adc_pkg.sv
// Constants for the auxiliary DPLL status and clock select block.
// Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
package adc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int FRAME_PERIOD_NS = 125000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MF_FRAMES = 4;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int FREQ_W = 24;
  localparam int LIM_W = 10;
  localparam int NUM_OC = 7;
  localparam int APLL_MULT_SHIFT = 2;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_AUXCTL = 8'h08;
  localparam logic [7:0] OFS_AUXFREQ = 8'h0c;
  localparam logic [7:0] OFS_APLLCTL = 8'h10;
  localparam logic [7:0] OFS_MAINFREQ = 8'h14;
  localparam logic [7:0] OFS_AUXFROMMAIN = 8'h18;
  localparam logic [7:0] OFS_PROG_MAIN = 8'h1c;
  localparam logic [7:0] OFS_PROG_AUX = 8'h20;
  localparam logic [7:0] OFS_PROG_MAIN2 = 8'h24;
  localparam logic [7:0] OFS_SYNCCTL = 8'h28;
  localparam logic [7:0] OFS_LIMIT1 = 8'h2c;
  localparam logic [7:0] OFS_LIMIT2 = 8'h30;
  localparam logic [7:0] OFS_OCSEL0 = 8'h34;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_LATCH_LOCK = 0;
  localparam int BIT_LATCH_NOIN = 1;
  localparam int BIT_SRC_MAIN = 0;
  localparam int BIT_LOWRATE_AUX = 1;
  localparam int BIT_PROG_MAIN = 2;
  localparam int BIT_PROG_AUX = 3;
  localparam int BIT_PROG_MAIN2 = 4;
  localparam int BIT_LIMIT_LOSS_OF_LOCK_EN = 16;
  // ----------------------------------------
  // Reset and fixed values (kHz)
  // ----------------------------------------
  localparam logic [23:0] MAIN2_FIXED_KHZ = 24'h04c4b4;
  localparam logic [23:0] AUXFREQ_RST = 24'h0025e8;
  localparam logic [23:0] MAINFREQ_RST = 24'h012fc8;
  localparam logic [23:0] KHZ_8K = 24'h000008;
  localparam logic [23:0] KHZ_2K = 24'h000002;
  localparam logic [9:0] HARD_LIM_RST = 10'h3ff;
  localparam logic [7:0] SOFT_LIM_RST = 8'hff;
  // ----------------------------------------
  // Output clock source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OC_OFF = 3'b000,
    OC_MAIN = 3'b001,
    OC_AUX = 3'b010,
    OC_MAIN2 = 3'b011,
    OC_LOW8K = 3'b100,
    OC_LOW2K = 3'b101
  } adc_oc_src_e;
endpackage

// ### adc_top.sv
// Auxiliary DPLL status, clock source selection, limits and sync outputs.
// Assumes synchronous inputs from the loops and a classic Wishbone master.
`timescale 1ns/1ps
// Summary of operation
// R1: Lock-change and no-input indications are sticky until software clears them.
// R2: Any locked/not-locked transition of the aux loop sets the lock-change bit.
// R3: No valid candidate reference sets the no-input bit.
// R4: Live aux lock state is readable apart from the sticky bit.
// R5: Nonzero force field overrides automatic aux reference choice.
// R6: Aux loop bandwidth and damping are set independently.
// R7: Each multiplier loop outputs four times its input frequency.
// R8: Second main analog loop runs at 312.5 MHz normally.
// R9: Source select feeds aux analog loop from aux or main DPLL.
// R10: Sourced from aux DPLL, aux loop input follows aux frequency setting.
// R11: Output clock options follow their loop's frequency when it changes.
// R12: Programmable mode replaces fixed loop frequencies with programmed ones.
// R13: Source select picks main or aux path for 2k and 8k options.
// R14: 8 kHz sync has enable, clock-or-pulse choice and inversion.
// R15: 2 kHz sync offers the same three choices.
// R16: Soft-limit breach raises status only, reference stays qualified.
// R17: Enabled hard-limit breach forces loss of lock on both loops.
// R18: Hard limit is ten bits split over two registers.
// R19: Event in clear cycle keeps the sticky bit set.
module adc_top #(
  parameter int FRAME_CYCLES = adc_pkg::FRAME_CYCLES,
  parameter int NUM_REFS = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic auxLoopLocked,
  input wire logic [NUM_REFS-1:0] auxRefValid,
  input wire logic [3:0] auxAutoRef,
  input wire logic [9:0] auxRefOffset,
  input wire logic [9:0] mainRefOffset,
  input wire logic mainFrameTick,
  input wire logic auxFrameTick,
  input wire logic mainMultiTick,
  input wire logic auxMultiTick,
  output logic [3:0] auxRefSel,
  output logic [3:0] auxLoopBw,
  output logic [2:0] dampingSel,
  output logic mainLossOfLock,
  output logic [23:0] auxApllInFreq,
  output logic [23:0] mainApllOutFreq,
  output logic [23:0] auxApllOutFreq,
  output logic [23:0] mainApllSecondFreq,
  output logic [adc_pkg::NUM_OC*24-1:0] ocFreq,
  output logic frameSync8k,
  output logic multiframeSync2k
);
  initial begin
    if (FRAME_CYCLES < 4 || FRAME_CYCLES > 8191 || NUM_REFS < 1 || NUM_REFS > 32) begin
      $error("adc_top: unsupported parameter value");
    end
  end
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic lockLatch_q;
  logic noInLatch_q;
  logic lockPrev_q;
  logic [3:0] auxRefForce_q;
  logic [3:0] auxLoopBw_q;
  logic [2:0] dampingSel_q;
  logic [23:0] auxFreqSel_q;
  logic [4:0] apllCtl_q;
  logic [23:0] mainApllInFreq_q;
  logic [23:0] auxFromMain_q;
  logic [23:0] progMain_q;
  logic [23:0] progAux_q;
  logic [23:0] progMain2_q;
  logic [5:0] syncCtl_q;
  logic [7:0] hardLimLo_q;
  logic [1:0] hardLimHi_q;
  logic [7:0] soft_freq_limit_q;
  logic limitLossOfLockEn_q;
  logic [4:0] ocSel_q [adc_pkg::NUM_OC];
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire busReq = wb_cyc_i && wb_stb_i && !ack_q;
  wire wrReq = busReq && wb_we_i;
  wire [31:0] wrData = {wb_sel_i[3] ? wb_dat_i[31:24] : 8'h00,
                        wb_sel_i[2] ? wb_dat_i[23:16] : 8'h00,
                        wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                        wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  wire wrLatch = wrReq && wb_adr_i == adc_pkg::OFS_LATCH;
  wire wrAuxCtl = wrReq && wb_adr_i == adc_pkg::OFS_AUXCTL;
  wire wrAuxFreq = wrReq && wb_adr_i == adc_pkg::OFS_AUXFREQ;
  wire wrApllCtl = wrReq && wb_adr_i == adc_pkg::OFS_APLLCTL;
  wire wrMainFreq = wrReq && wb_adr_i == adc_pkg::OFS_MAINFREQ;
  wire wrAuxFromMain = wrReq && wb_adr_i == adc_pkg::OFS_AUXFROMMAIN;
  wire wrProgMain = wrReq && wb_adr_i == adc_pkg::OFS_PROG_MAIN;
  wire wrProgAux = wrReq && wb_adr_i == adc_pkg::OFS_PROG_AUX;
  wire wrProgMain2 = wrReq && wb_adr_i == adc_pkg::OFS_PROG_MAIN2;
  wire wrSyncCtl = wrReq && wb_adr_i == adc_pkg::OFS_SYNCCTL;
  wire wrLimit1 = wrReq && wb_adr_i == adc_pkg::OFS_LIMIT1;
  wire wrLimit2 = wrReq && wb_adr_i == adc_pkg::OFS_LIMIT2;
  // ----------------------------------------
  // Limit supervision and lock state
  // ----------------------------------------
  wire [9:0] hardFreqLimit = {hardLimHi_q, hardLimLo_q}; // [R18]
  wire auxSoftLimitFlag = auxRefOffset > {2'b00, soft_freq_limit_q}; // [R16]
  wire mainSoftLimitFlag = mainRefOffset > {2'b00, soft_freq_limit_q}; // [R16]
  wire auxHardBreach = limitLossOfLockEn_q && auxRefOffset > hardFreqLimit;
  wire mainHardBreach = limitLossOfLockEn_q && mainRefOffset > hardFreqLimit;
  wire auxLockState = auxLoopLocked && !auxHardBreach; // [R17] [R4]
  wire auxNoValidInput = auxRefValid == '0; // [R3]
  wire lockChange = auxLockState != lockPrev_q; // [R2]
  wire lockClr = wrLatch && wrData[adc_pkg::BIT_LATCH_LOCK];
  wire noInClr = wrLatch && wrData[adc_pkg::BIT_LATCH_NOIN];
  assign mainLossOfLock = mainHardBreach; // [R17]
  // ----------------------------------------
  // Frequency derivation
  // ----------------------------------------
  wire [23:0] mainBase = apllCtl_q[adc_pkg::BIT_PROG_MAIN] ? progMain_q : mainApllInFreq_q;
  wire [23:0] auxSrcFreq = apllCtl_q[adc_pkg::BIT_SRC_MAIN] ? auxFromMain_q : auxFreqSel_q;
  wire [23:0] auxBase = apllCtl_q[adc_pkg::BIT_PROG_AUX] ? progAux_q : auxSrcFreq;
  wire [23:0] mainOut = mainBase << adc_pkg::APLL_MULT_SHIFT;
  wire [23:0] auxOut = auxBase << adc_pkg::APLL_MULT_SHIFT;
  wire [23:0] main2Prog = progMain2_q << adc_pkg::APLL_MULT_SHIFT;
  wire [23:0] main2Out = apllCtl_q[adc_pkg::BIT_PROG_MAIN2] ? main2Prog
                                                             : adc_pkg::MAIN2_FIXED_KHZ;
  assign auxApllInFreq = auxSrcFreq; // [R9] [R10]
  assign mainApllOutFreq = mainOut; // [R7] [R12]
  assign auxApllOutFreq = auxOut; // [R7] [R12]
  assign mainApllSecondFreq = main2Out; // [R8] [R12]
  assign auxRefSel = auxRefForce_q != 4'h0 ? auxRefForce_q - 4'h1 : auxAutoRef; // [R5]
  assign auxLoopBw = auxLoopBw_q; // [R6]
  assign dampingSel = dampingSel_q; // [R6]
  // Output clock options
  genvar gi;
  generate
    for (gi = 0; gi < adc_pkg::NUM_OC; gi++) begin : g_oc
      localparam logic [7:0] OCOFS = adc_pkg::OFS_OCSEL0 + 8'(4 * gi);
      wire wrOc = wrReq && wb_adr_i == OCOFS;
      wire [2:0] srcCode = ocSel_q[gi][2:0];
      wire [23:0] ocBase = srcCode == adc_pkg::OC_MAIN ? mainOut :
                           srcCode == adc_pkg::OC_AUX ? auxOut :
                           srcCode == adc_pkg::OC_MAIN2 ? main2Out :
                           srcCode == adc_pkg::OC_LOW8K ? adc_pkg::KHZ_8K :
                           srcCode == adc_pkg::OC_LOW2K ? adc_pkg::KHZ_2K : 24'h000000;
      wire [23:0] ocDiv = ocBase >> ocSel_q[gi][4:3];
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          ocSel_q[gi] <= 5'h00;
          ocFreq[gi*24 +: 24] <= 24'h000000;
        end else begin
          if (wrOc) begin
            ocSel_q[gi] <= wrData[4:0];
          end
          ocFreq[gi*24 +: 24] <= ocDiv; // [R11] [R12]
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Sync outputs
  // ----------------------------------------
  logic [12:0] frameCnt_q;
  logic [1:0] mfCnt_q;
  wire lowAux = apllCtl_q[adc_pkg::BIT_LOWRATE_AUX];
  wire frameTick = lowAux ? auxFrameTick : mainFrameTick; // [R13]
  wire multiTick = lowAux ? auxMultiTick : mainMultiTick; // [R13]
  wire frameWrap = frameCnt_q == 13'(FRAME_CYCLES - 1);
  wire fsRaw = syncCtl_q[1] ? frameCnt_q == 13'h0000 : frameCnt_q < 13'(FRAME_CYCLES / 2);
  wire mfsRaw = syncCtl_q[4] ? (frameCnt_q == 13'h0000 && mfCnt_q == 2'h0)
                             : mfCnt_q < 2'(adc_pkg::MF_FRAMES / 2);
  wire fs_d = syncCtl_q[0] && (fsRaw ^ syncCtl_q[2]); // [R14]
  wire mfs_d = syncCtl_q[3] && (mfsRaw ^ syncCtl_q[5]); // [R15]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frameCnt_q <= 13'h0000;
      mfCnt_q <= 2'h0;
      frameSync8k <= 1'b0;
      multiframeSync2k <= 1'b0;
    end else begin
      frameCnt_q <= (frameTick || frameWrap) ? 13'h0000 : frameCnt_q + 13'h0001;
      if (multiTick) begin
        mfCnt_q <= 2'h0;
      end else if (frameTick || frameWrap) begin
        mfCnt_q <= mfCnt_q + 2'h1;
      end
      frameSync8k <= fs_d;
      multiframeSync2k <= mfs_d;
    end
  end
  // ----------------------------------------
  // Status latches
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lockPrev_q <= 1'b0;
      lockLatch_q <= 1'b0;
      noInLatch_q <= 1'b0;
    end else begin
      lockPrev_q <= auxLockState;
      lockLatch_q <= lockChange || (lockLatch_q && !lockClr); // [R1] [R2] [R19]
      noInLatch_q <= auxNoValidInput || (noInLatch_q && !noInClr); // [R1] [R3] [R19]
    end
  end
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      auxRefForce_q <= 4'h0;
      auxLoopBw_q <= 4'h0;
      dampingSel_q <= 3'h0;
      auxFreqSel_q <= adc_pkg::AUXFREQ_RST;
      apllCtl_q <= 5'h00;
      mainApllInFreq_q <= adc_pkg::MAINFREQ_RST;
      auxFromMain_q <= adc_pkg::MAINFREQ_RST;
      progMain_q <= 24'h000000;
      progAux_q <= 24'h000000;
      progMain2_q <= 24'h000000;
      syncCtl_q <= 6'h00;
      hardLimLo_q <= adc_pkg::HARD_LIM_RST[7:0];
      hardLimHi_q <= adc_pkg::HARD_LIM_RST[9:8];
      soft_freq_limit_q <= adc_pkg::SOFT_LIM_RST;
      limitLossOfLockEn_q <= 1'b0;
    end else begin
      if (wrAuxCtl) begin
        auxRefForce_q <= wrData[3:0]; // [R5]
        auxLoopBw_q <= wrData[7:4]; // [R6]
        dampingSel_q <= wrData[10:8]; // [R6]
      end
      if (wrAuxFreq) auxFreqSel_q <= wrData[23:0];
      if (wrApllCtl) apllCtl_q <= wrData[4:0];
      if (wrMainFreq) mainApllInFreq_q <= wrData[23:0];
      if (wrAuxFromMain) auxFromMain_q <= wrData[23:0];
      if (wrProgMain) progMain_q <= wrData[23:0];
      if (wrProgAux) progAux_q <= wrData[23:0];
      if (wrProgMain2) progMain2_q <= wrData[23:0];
      if (wrSyncCtl) syncCtl_q <= wrData[5:0];
      if (wrLimit1) hardLimLo_q <= wrData[7:0]; // [R18]
      if (wrLimit2) begin
        hardLimHi_q <= wrData[1:0]; // [R18]
        soft_freq_limit_q <= wrData[15:8];
        limitLossOfLockEn_q <= wrData[adc_pkg::BIT_LIMIT_LOSS_OF_LOCK_EN];
      end
    end
  end
  // ----------------------------------------
  // Read path and acknowledge
  // ----------------------------------------
  always_comb begin
    rdat_d = 32'h00000000;
    if (wb_adr_i == adc_pkg::OFS_STATUS) begin
      rdat_d = {28'h0000000, mainLossOfLock, mainSoftLimitFlag, auxSoftLimitFlag, auxLockState};
    end else if (wb_adr_i == adc_pkg::OFS_LATCH) begin
      rdat_d = {30'h00000000, noInLatch_q, lockLatch_q};
    end else if (wb_adr_i == adc_pkg::OFS_AUXCTL) begin
      rdat_d = {21'h000000, dampingSel_q, auxLoopBw_q, auxRefForce_q};
    end else if (wb_adr_i == adc_pkg::OFS_AUXFREQ) begin
      rdat_d = {8'h00, auxFreqSel_q};
    end else if (wb_adr_i == adc_pkg::OFS_APLLCTL) begin
      rdat_d = {27'h0000000, apllCtl_q};
    end else if (wb_adr_i == adc_pkg::OFS_MAINFREQ) begin
      rdat_d = {8'h00, mainApllInFreq_q};
    end else if (wb_adr_i == adc_pkg::OFS_AUXFROMMAIN) begin
      rdat_d = {8'h00, auxFromMain_q};
    end else if (wb_adr_i == adc_pkg::OFS_PROG_MAIN) begin
      rdat_d = {8'h00, progMain_q};
    end else if (wb_adr_i == adc_pkg::OFS_PROG_AUX) begin
      rdat_d = {8'h00, progAux_q};
    end else if (wb_adr_i == adc_pkg::OFS_PROG_MAIN2) begin
      rdat_d = {8'h00, progMain2_q};
    end else if (wb_adr_i == adc_pkg::OFS_SYNCCTL) begin
      rdat_d = {26'h0000000, syncCtl_q};
    end else if (wb_adr_i == adc_pkg::OFS_LIMIT1) begin
      rdat_d = {24'h000000, hardLimLo_q};
    end else if (wb_adr_i == adc_pkg::OFS_LIMIT2) begin
      rdat_d = {15'h0000, limitLossOfLockEn_q, soft_freq_limit_q, 6'h00, hardLimHi_q};
    end else begin
      for (int i = 0; i < adc_pkg::NUM_OC; i++) begin
        if (wb_adr_i == adc_pkg::OFS_OCSEL0 + 8'(4 * i)) begin
          rdat_d = {27'h0000000, ocSel_q[i]};
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= busReq;
      if (busReq) rdat_q <= rdat_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_lock_change_latch: assert property (lockChange |=> lockLatch_q) // [R2]
    else $error("lock change not latched");
  a_noin_latch: assert property (auxNoValidInput |=> noInLatch_q) // [R3]
    else $error("no-input not latched");
  a_latch_sticky: assert property (lockLatch_q && !lockClr |=> lockLatch_q) // [R1]
    else $error("lock latch dropped without clear");
  a_lock_clear: assert property (lockClr && !lockChange |=> !lockLatch_q) // [R1]
    else $error("lock latch not cleared");
  a_noin_clear: assert property (noInClr && !auxNoValidInput |=> !noInLatch_q) // [R1]
    else $error("no-input latch not cleared");
  a_set_beats_clear: assert property (noInClr && auxNoValidInput |=> noInLatch_q) // [R19]
    else $error("clear beat a coincident event");
  a_live_lock_state: assert property (auxLoopLocked && !auxHardBreach |-> auxLockState) // [R4]
    else $error("live lock state wrong");
  a_force_overrides: assert property ( // [R5]
    auxRefForce_q != 4'h0 |-> auxRefSel == auxRefForce_q - 4'h1)
    else $error("forced reference ignored");
  a_soft_keeps_ref: assert property ( // [R16]
    auxSoftLimitFlag && auxRefForce_q == 4'h0 |-> auxRefSel == auxAutoRef)
    else $error("soft limit changed the reference");
  a_ctl_fields_write: assert property ( // [R6]
    wrAuxCtl |=> auxLoopBw == $past(wrData[7:4]) && dampingSel == $past(wrData[10:8]))
    else $error("bandwidth or damping not written");
  a_apll_times_four: assert property (auxApllOutFreq == 24'(auxBase * 4)) // [R7]
    else $error("aux multiplier not four times");
  a_main2_fixed_rate: assert property ( // [R8]
    !apllCtl_q[adc_pkg::BIT_PROG_MAIN2] |-> mainApllSecondFreq == 24'h04c4b4)
    else $error("second main loop not 312.5 MHz");
  a_aux_src_follow: assert property ( // [R10]
    !apllCtl_q[adc_pkg::BIT_SRC_MAIN] |-> auxApllInFreq == auxFreqSel_q)
    else $error("aux loop input not following aux setting");
  a_aux_src_main: assert property ( // [R9]
    apllCtl_q[adc_pkg::BIT_SRC_MAIN] |-> auxApllInFreq == auxFromMain_q)
    else $error("aux loop input not taken from main path");
  a_hard_limit_lol: assert property ( // [R17]
    limitLossOfLockEn_q && mainRefOffset > hardFreqLimit |-> mainLossOfLock)
    else $error("hard limit did not force main loss of lock");
  a_aux_limit_unlock: assert property ( // [R17]
    limitLossOfLockEn_q && auxRefOffset > hardFreqLimit |-> !auxLockState)
    else $error("hard limit did not unlock aux loop");
  a_lowrate_select: assert property ( // [R13]
    lowAux && auxFrameTick |=> frameCnt_q == 13'h0000)
    else $error("aux frame tick not used");
  a_fs_disabled_low: assert property (!syncCtl_q[0] |=> !frameSync8k) // [R14]
    else $error("disabled 8k sync toggled");
  a_mfs_disabled_low: assert property (!syncCtl_q[3] |=> !multiframeSync2k) // [R15]
    else $error("disabled 2k sync toggled");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (busReq |=> wb_ack_o)
    else $error("request not acknowledged");
  c_lock_loss: cover property (auxLockState ##1 !auxLockState);
  c_clear_with_event: cover property (noInClr && auxNoValidInput);
  c_hard_breach: cover property (mainLossOfLock);
  c_fs_pulse: cover property (syncCtl_q[0] && syncCtl_q[1] && frameSync8k);
  c_mfs_pulse: cover property (syncCtl_q[3] && syncCtl_q[4] && multiframeSync2k);
endmodule

// ### test_adc_top.sv
// Self-checking bench for the aux DPLL status and clock select block.
// Assumes adc_pkg and adc_top are compiled first; the bench drives every port.
`timescale 1ns/1ps
module test_adc_top;
  localparam int FC = 16;
  logic core_clk = 0;
  logic resetn = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o;
  logic auxLoopLocked = 0;
  logic [7:0] auxRefValid = 8'hff;
  logic [3:0] auxAutoRef = '0, auxRefSel, auxLoopBw, autoRef;
  logic [9:0] auxRefOffset = '0, mainRefOffset = '0;
  logic mainFrameTick = 0, auxFrameTick = 0, mainMultiTick = 0, auxMultiTick = 0;
  logic [2:0] dampingSel;
  logic mainLossOfLock, frameSync8k, multiframeSync2k;
  logic [23:0] auxApllInFreq, mainApllOutFreq, auxApllOutFreq, mainApllSecondFreq;
  logic [adc_pkg::NUM_OC*24-1:0] ocFreq;
  logic [23:0] fAux, fMain, pA, pM, pM2, exp24;
  logic [31:0] expQ[$];
  logic [31:0] obsVal = '0, actV, expV, cnt;
  logic obsValid = 0;
  int failures = 0;
  int comparisons = 0;

  always #12.5 core_clk = ~core_clk;

  adc_top #(.FRAME_CYCLES(FC), .NUM_REFS(8)) u_adc_top (
    .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .auxLoopLocked, .auxRefValid, .auxAutoRef,
    .auxRefOffset, .mainRefOffset, .mainFrameTick, .auxFrameTick, .mainMultiTick,
    .auxMultiTick, .auxRefSel, .auxLoopBw, .dampingSel, .mainLossOfLock,
    .auxApllInFreq, .mainApllOutFreq, .auxApllOutFreq, .mainApllSecondFreq,
    .ocFreq, .frameSync8k, .multiframeSync2k);

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    if ((wb_ack_o === 1'b1 && wb_we_i === 1'b0) || obsValid) begin
      actV = obsValid ? obsVal : wb_dat_o;
      expV = expQ.pop_front();
      comparisons++;
      if (actV !== expV) begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, actV, expV);
      end
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wbAcc(1'b1, adr, dat, 4'hf);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    wbAcc(1'b0, adr, '0, 4'hf);
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    expQ.push_back(exp);
    @(posedge core_clk);
    obsVal <= act;
    obsValid <= 1;
    @(posedge core_clk);
    obsValid <= 0;
  endtask

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  task automatic cntHigh(input bit mf, input int n);
    cnt = '0;
    repeat (n) begin
      @(posedge core_clk);
      cnt = cnt + (mf ? multiframeSync2k : frameSync8k);
    end
  endtask

  task automatic tick(input bit aux);
    @(posedge core_clk);
    if (aux) begin
      auxFrameTick <= 1;
      auxMultiTick <= 1;
    end else begin
      mainFrameTick <= 1;
      mainMultiTick <= 1;
    end
    @(posedge core_clk);
    {auxFrameTick, auxMultiTick, mainFrameTick, mainMultiTick} <= 4'h0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(71159));
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    rd(adc_pkg::OFS_AUXFREQ, {8'h0, adc_pkg::AUXFREQ_RST});
    rd(adc_pkg::OFS_LIMIT1, 32'h000000ff);
    rd(adc_pkg::OFS_LIMIT2, 32'h0000ff03);
    rd(adc_pkg::OFS_STATUS, 32'h0);
    wr(8'h50, 32'hffffffff);
    rd(8'h50, 32'h0);
    $display("test reset and map done");
    @(posedge core_clk);
    auxLoopLocked <= 1;
    rd(adc_pkg::OFS_LATCH, 32'h1);
    rd(adc_pkg::OFS_STATUS, 32'h1);
    wr(adc_pkg::OFS_LATCH, 32'h1);
    rd(adc_pkg::OFS_LATCH, 32'h0);
    @(posedge core_clk);
    auxLoopLocked <= 0;
    rd(adc_pkg::OFS_LATCH, 32'h1);
    wr(adc_pkg::OFS_LATCH, 32'h1);
    @(posedge core_clk);
    auxRefValid <= 8'h00;
    rd(adc_pkg::OFS_LATCH, 32'h2);
    wr(adc_pkg::OFS_LATCH, 32'h2);
    rd(adc_pkg::OFS_LATCH, 32'h2);
    @(posedge core_clk);
    auxRefValid <= 8'($urandom_range(255, 1));
    rd(adc_pkg::OFS_LATCH, 32'h2);
    wr(adc_pkg::OFS_LATCH, 32'h3);
    rd(adc_pkg::OFS_LATCH, 32'h0);
    $display("test latched status done");
    autoRef = 4'($urandom_range(15));
    @(posedge core_clk);
    auxAutoRef <= autoRef;
    wr(adc_pkg::OFS_AUXCTL, 32'h000005a3);
    settle();
    chk(auxRefSel, 32'h2);
    chk(auxLoopBw, 32'ha);
    chk(dampingSel, 32'h5);
    wr(adc_pkg::OFS_AUXCTL, 32'h00000600);
    settle();
    chk(auxRefSel, autoRef);
    chk({auxLoopBw, 1'b0, dampingSel}, 32'h06);
    $display("test aux control done");
    wbAcc(1'b1, adc_pkg::OFS_AUXFREQ, 32'hffffffff, 4'h1);
    rd(adc_pkg::OFS_AUXFREQ, 32'h000000ff);
    fAux = 24'($urandom_range(24'h3fffff, 1));
    wr(adc_pkg::OFS_AUXFREQ, {8'h0, fAux});
    settle();
    chk(auxApllInFreq, fAux);
    chk(auxApllOutFreq, fAux << 2);
    chk(mainApllOutFreq, adc_pkg::MAINFREQ_RST << 2);
    chk(mainApllSecondFreq, adc_pkg::MAIN2_FIXED_KHZ);
    fMain = 24'($urandom_range(24'h3fffff, 1));
    wr(adc_pkg::OFS_AUXFROMMAIN, {8'h0, fMain});
    wr(adc_pkg::OFS_APLLCTL, 32'h1);
    settle();
    chk(auxApllInFreq, fMain);
    pM = 24'($urandom_range(24'h3fffff, 1));
    pA = 24'($urandom_range(24'h3fffff, 1));
    pM2 = 24'($urandom_range(24'h3fffff, 1));
    wr(adc_pkg::OFS_PROG_MAIN, {8'h0, pM});
    wr(adc_pkg::OFS_PROG_AUX, {8'h0, pA});
    wr(adc_pkg::OFS_PROG_MAIN2, {8'h0, pM2});
    wr(adc_pkg::OFS_APLLCTL, 32'h1d);
    settle();
    chk(mainApllOutFreq, pM << 2);
    chk(auxApllOutFreq, pA << 2);
    chk(mainApllSecondFreq, pM2 << 2);
    wr(adc_pkg::OFS_APLLCTL, 32'h0);
    $display("test loop frequencies done");
    for (int i = 0; i < 7; i++) begin
      wr(adc_pkg::OFS_OCSEL0 + 8'(4 * i), {27'h0, 2'(i % 4), 3'(i % 6)});
    end
    settle();
    for (int i = 0; i < 7; i++) begin
      case (i % 6)
        1: exp24 = adc_pkg::MAINFREQ_RST << 2;
        2: exp24 = fAux << 2;
        3: exp24 = adc_pkg::MAIN2_FIXED_KHZ;
        4: exp24 = adc_pkg::KHZ_8K;
        5: exp24 = adc_pkg::KHZ_2K;
        default: exp24 = '0;
      endcase
      chk(ocFreq[24*i +: 24], exp24 >> (i % 4));
    end
    fAux = 24'($urandom_range(24'h3fffff, 1));
    wr(adc_pkg::OFS_AUXFREQ, {8'h0, fAux});
    settle();
    exp24 = fAux << 2;
    chk(ocFreq[71:48], exp24 >> 2);
    $display("test output clocks done");
    wr(adc_pkg::OFS_SYNCCTL, 32'h09);
    cntHigh(0, FC);
    chk(cnt, FC / 2);
    cntHigh(1, 4 * FC);
    chk(cnt, 2 * FC);
    wr(adc_pkg::OFS_SYNCCTL, 32'h1b);
    cntHigh(0, FC);
    chk(cnt, 1);
    cntHigh(1, 4 * FC);
    chk(cnt, 1);
    wr(adc_pkg::OFS_SYNCCTL, 32'h3f);
    cntHigh(0, FC);
    chk(cnt, FC - 1);
    cntHigh(1, 4 * FC);
    chk(cnt, 4 * FC - 1);
    wr(adc_pkg::OFS_SYNCCTL, 32'h00);
    cntHigh(0, FC);
    chk(cnt, 0);
    wr(adc_pkg::OFS_SYNCCTL, 32'h1b);
    tick(0);
    chk({frameSync8k, multiframeSync2k}, 32'h3);
    wr(adc_pkg::OFS_APLLCTL, 32'h2);
    tick(1);
    chk({frameSync8k, multiframeSync2k}, 32'h3);
    tick(0);
    chk({frameSync8k, multiframeSync2k}, 32'h0);
    $display("test sync outputs done");
    @(posedge core_clk);
    auxLoopLocked <= 1;
    auxRefOffset <= 10'h041;
    mainRefOffset <= 10'h041;
    wr(adc_pkg::OFS_LIMIT1, 32'h0);
    wr(adc_pkg::OFS_LIMIT2, 32'h00004002);
    rd(adc_pkg::OFS_STATUS, 32'h7);
    chk(auxRefSel, autoRef);
    @(posedge core_clk);
    auxRefOffset <= 10'h200;
    mainRefOffset <= 10'h200;
    wr(adc_pkg::OFS_LIMIT2, 32'h00014002);
    settle();
    chk(mainLossOfLock, 0);
    rd(adc_pkg::OFS_STATUS, 32'h7);
    @(posedge core_clk);
    auxRefOffset <= 10'h201;
    mainRefOffset <= 10'h201;
    settle();
    chk(mainLossOfLock, 1);
    rd(adc_pkg::OFS_STATUS, 32'he);
    wr(adc_pkg::OFS_LIMIT2, 32'h00004002);
    settle();
    chk(mainLossOfLock, 0);
    rd(adc_pkg::OFS_STATUS, 32'h7);
    $display("test frequency limits done");
    finish_test();
  end
endmodule
